// ---- hdl/ext_osc_pkg.sv ----
// Package: register map, field layout and constants of the external oscillator control
package ext_osc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  XOSC_CTRL_SFR   = 8'hB1;
   localparam logic [11:0] ADDR_CTRL       = 12'h2C4;
   localparam logic [11:0] ADDR_STATUS     = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STAT   = 12'h004;
   localparam logic [11:0] ADDR_IRQ_EN     = 12'h008;
   localparam logic [11:0] ADDR_IRQ_CLR    = 12'h00C;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  CTRL_WR_MASK    = 8'h77;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int VALID_BIT   = 7;
   localparam int MODE_LSB    = 4;
   localparam int FREQ_LSB    = 0;
   localparam int IRQ_W       = 3;
   localparam int IRQ_VALID_UP   = 0;
   localparam int IRQ_VALID_DOWN = 1;
   localparam int IRQ_BAD_WR     = 2;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ          = 10_000_000;
   localparam int SETTLE_US       = 1000;
   localparam int SETTLE_CYC      = (CLK_HZ / 1_000_000) * SETTLE_US;
   localparam int EXT_DIV         = 8;
   localparam int STABLE_EDGES    = 16;

   typedef enum logic [2:0] {
      MODE_OFF0     = 3'b000,
      MODE_OFF1     = 3'b001,
      MODE_CMOS     = 3'b010,
      MODE_CMOS_DV2 = 3'b011,
      MODE_RC       = 3'b100,
      MODE_CAP      = 3'b101,
      MODE_XTAL     = 3'b110,
      MODE_XTAL_DV2 = 3'b111
   } osc_mode_e;

   typedef struct packed {
      logic       drive_en;
      logic       xtal_amp_en;
      logic       cmos_in_en;
      logic       rc_en;
      logic       cap_en;
      logic [2:0] freq_ctrl;
   } analog_ctl_s;
endpackage

// ---- hdl/ext_clk_div8_sync.sv ----
// Divide-by-8 of the synchronised external clock, as system-clock enable pulses
`timescale 1ns/10ps
module ext_clk_div8_sync #(
   parameter int DIV = ext_osc_pkg::EXT_DIV
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic ext_clk_async,
   input  wire logic run,
   output logic      ext_edge,
   output logic      tick_div8
);
   localparam int CW = $clog2(DIV);

   typedef struct packed {
      logic [1:0]    sync;
      logic          last;
      logic [CW-1:0] cnt;
      logic          tick;
   } div_s;

   div_s st_ff;
   div_s nxt_st;

   // ****************************************
   // Resync and divide
   // ****************************************
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.sync = {st_ff.sync[0], ext_clk_async};
      nxt_st.last = st_ff.sync[1];
      nxt_st.tick = 1'b0;
      if (!run) begin
         nxt_st.cnt = '0;
      end else if (st_ff.sync[1] && !st_ff.last) begin
         // One sysclk pulse per 8 source edges, jitter within one sysclk cycle
         if (st_ff.cnt == CW'(DIV - 1)) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign ext_edge  = st_ff.sync[1] & ~st_ff.last;
   assign tick_div8 = st_ff.tick;
endmodule

// ---- hdl/ext_osc_ctrl.sv ----
// External oscillator control: APB register, mode decode, valid flag, divided clock
// Notes on behaviour
// - The external clock divided by 8 is offered to the timers and counter array.
// - The divided clock is resynchronised to the system clock two to three cycles after the source edge.
// - The read-only crystal valid flag at bit 7 is 0 until the crystal runs stable.
// - Mode codes 000 and 001 keep the oscillator circuit off.
// - Code 010 is a direct CMOS clock, 011 the same clock halved.
// - Code 100 selects RC operation and 101 capacitor operation.
// - Code 110 selects crystal operation and 111 crystal halved.
// - Bit 3 is reserved, reads 0, and software writes 0 to it.
`timescale 1ns/10ps
module ext_osc_ctrl #(
   parameter int SETTLE_CYC   = ext_osc_pkg::SETTLE_CYC,
   parameter int STABLE_EDGES = ext_osc_pkg::STABLE_EDGES
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               clk_en,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               osc_in,
   output ext_osc_pkg::analog_ctl_s analog_ctl,
   output logic                    ext_clk_out,
   output logic                    ext_div8_tick,
   output logic                    irq
);
   localparam int SCW = $clog2(SETTLE_CYC + 1);
   localparam int ECW = $clog2(STABLE_EDGES + 1);

   typedef struct packed {
      logic [7:0]                     ctrl;
      logic [SCW-1:0]                 settle;
      logic [ECW-1:0]                 edges;
      logic                           valid;
      logic                           half;
      logic                           clk_out;
      logic [ext_osc_pkg::IRQ_W-1:0]  stat;
      logic [ext_osc_pkg::IRQ_W-1:0]  en;
      logic [31:0]                    rdata;
      ext_osc_pkg::analog_ctl_s       actl;
   } st_s;

   st_s  st_ff;
   st_s  nxt_st;
   logic ext_edge;
   logic run;
   logic wr;
   logic rd;
   logic [ext_osc_pkg::IRQ_W-1:0] ev;

   function automatic logic is_xtal(input logic [7:0] c);
      return c[ext_osc_pkg::MODE_LSB + 2] & c[ext_osc_pkg::MODE_LSB + 1];
   endfunction

   function automatic ext_osc_pkg::osc_mode_e mode_of(input logic [7:0] c);
      return ext_osc_pkg::osc_mode_e'(c[ext_osc_pkg::MODE_LSB +: 3]);
   endfunction

   // ****************************************
   // Divided clock for peripherals
   // ****************************************
   assign run = st_ff.actl.drive_en;

   ext_clk_div8_sync u_div (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .clk_en        (clk_en),
      .ext_clk_async (osc_in),
      .run           (run),
      .ext_edge      (ext_edge),
      .tick_div8     (ext_div8_tick)
   );

   // ****************************************
   // APB decode
   // ****************************************
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = st_ff.rdata;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      ev     = '0;
      if (wr && paddr == ext_osc_pkg::ADDR_CTRL) begin
         // Reserved bit and valid flag are not writable
         nxt_st.ctrl = pwdata[7:0] & ext_osc_pkg::CTRL_WR_MASK;
         ev[ext_osc_pkg::IRQ_BAD_WR] = pwdata[3];
      end
      if (wr && paddr == ext_osc_pkg::ADDR_IRQ_EN) begin
         nxt_st.en = pwdata[ext_osc_pkg::IRQ_W-1:0];
      end
      // Crystal settle timer and edge count for the valid flag
      if (!is_xtal(nxt_st.ctrl)) begin
         nxt_st.settle = '0;
         nxt_st.edges  = '0;
         nxt_st.valid  = 1'b0;
      end else begin
         if (st_ff.settle != SCW'(SETTLE_CYC)) begin
            nxt_st.settle = st_ff.settle + SCW'(1);
         end
         if (ext_edge && st_ff.edges != ECW'(STABLE_EDGES)) begin
            nxt_st.edges = st_ff.edges + ECW'(1);
         end
         nxt_st.valid = (st_ff.settle == SCW'(SETTLE_CYC)) &&
                        (st_ff.edges == ECW'(STABLE_EDGES));
      end
      ev[ext_osc_pkg::IRQ_VALID_UP]   = nxt_st.valid & ~st_ff.valid;
      ev[ext_osc_pkg::IRQ_VALID_DOWN] = ~nxt_st.valid & st_ff.valid;
      // Set wins over clear
      nxt_st.stat = st_ff.stat;
      if (wr && paddr == ext_osc_pkg::ADDR_IRQ_CLR) begin
         nxt_st.stat = st_ff.stat & ~pwdata[ext_osc_pkg::IRQ_W-1:0];
      end
      nxt_st.stat = nxt_st.stat | ev;
      // Analog control decode
      nxt_st.actl           = '0;
      nxt_st.actl.freq_ctrl = nxt_st.ctrl[ext_osc_pkg::FREQ_LSB +: 3];
      unique case (mode_of(nxt_st.ctrl))
         ext_osc_pkg::MODE_OFF0, ext_osc_pkg::MODE_OFF1: begin
            nxt_st.actl.drive_en = 1'b0;
         end
         ext_osc_pkg::MODE_CMOS, ext_osc_pkg::MODE_CMOS_DV2: begin
            nxt_st.actl.drive_en   = 1'b1;
            nxt_st.actl.cmos_in_en = 1'b1;
         end
         ext_osc_pkg::MODE_RC: begin
            nxt_st.actl.drive_en = 1'b1;
            nxt_st.actl.rc_en    = 1'b1;
         end
         ext_osc_pkg::MODE_CAP: begin
            nxt_st.actl.drive_en = 1'b1;
            nxt_st.actl.cap_en   = 1'b1;
         end
         ext_osc_pkg::MODE_XTAL, ext_osc_pkg::MODE_XTAL_DV2: begin
            nxt_st.actl.drive_en    = 1'b1;
            nxt_st.actl.xtal_amp_en = 1'b1;
         end
      endcase
      // Oscillator output: direct, or halved in modes 011 and 111
      if (!st_ff.actl.drive_en) begin
         nxt_st.half    = 1'b0;
         nxt_st.clk_out = 1'b0;
      end else if (ext_edge) begin
         nxt_st.half = ~st_ff.half;
         if (st_ff.ctrl[ext_osc_pkg::MODE_LSB] && st_ff.ctrl[ext_osc_pkg::MODE_LSB + 1]) begin
            nxt_st.clk_out = ~st_ff.half;
         end else begin
            nxt_st.clk_out = 1'b1;
         end
      end else if (!(st_ff.ctrl[ext_osc_pkg::MODE_LSB] &&
                     st_ff.ctrl[ext_osc_pkg::MODE_LSB + 1])) begin
         nxt_st.clk_out = 1'b0;
      end
      // Read data captured in setup phase
      nxt_st.rdata = '0;
      if (rd) begin
         unique case (paddr)
            ext_osc_pkg::ADDR_CTRL: begin
               nxt_st.rdata[7:0] = {st_ff.valid, st_ff.ctrl[6:4], 1'b0, st_ff.ctrl[2:0]};
            end
            ext_osc_pkg::ADDR_STATUS: begin
               nxt_st.rdata[2:0] = {st_ff.actl.drive_en, st_ff.half, st_ff.valid};
            end
            ext_osc_pkg::ADDR_IRQ_STAT: begin
               nxt_st.rdata[ext_osc_pkg::IRQ_W-1:0] = st_ff.stat;
            end
            ext_osc_pkg::ADDR_IRQ_EN: begin
               nxt_st.rdata[ext_osc_pkg::IRQ_W-1:0] = st_ff.en;
            end
            default: begin
               nxt_st.rdata = '0;
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff      <= '0;
         st_ff.ctrl <= ext_osc_pkg::CTRL_RESET;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign analog_ctl  = st_ff.actl;
   assign ext_clk_out = st_ff.clk_out;
   assign irq         = |(st_ff.stat & st_ff.en);

   // ****************************************
   // Assertions
   // ****************************************
   property p_off_modes;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_ff.ctrl[6:5] == 2'b00) |-> !analog_ctl.drive_en;
   endproperty
   a_off_modes: assert property (p_off_modes) else $error("oscillator on in off mode");

   property p_valid_only_xtal;
      @(posedge clk_sys) disable iff (!rst_n)
      !is_xtal(st_ff.ctrl) |-> !st_ff.valid;
   endproperty
   a_valid_only_xtal: assert property (p_valid_only_xtal) else $error("valid outside xtal");

   property p_valid_needs_settle;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(st_ff.valid) |-> $past(st_ff.settle) == SCW'(SETTLE_CYC);
   endproperty
   a_valid_needs_settle: assert property (p_valid_needs_settle) else $error("valid early");

   property p_rsvd_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      st_ff.ctrl[3] == 1'b0 && st_ff.ctrl[7] == 1'b0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

   property p_cmos_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_ff.ctrl[6:5] == 2'b01) |-> analog_ctl.cmos_in_en && !analog_ctl.rc_en;
   endproperty
   a_cmos_sel: assert property (p_cmos_sel) else $error("cmos not selected");

   property p_rc_cap_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_ff.ctrl[6:5] == 2'b10) |-> (analog_ctl.rc_en != analog_ctl.cap_en) &&
                                      (analog_ctl.cap_en == st_ff.ctrl[4]);
   endproperty
   a_rc_cap_sel: assert property (p_rc_cap_sel) else $error("rc/cap wrong");

   property p_xtal_sel;
      @(posedge clk_sys) disable iff (!rst_n)
      is_xtal(st_ff.ctrl) |-> analog_ctl.xtal_amp_en;
   endproperty
   a_xtal_sel: assert property (p_xtal_sel) else $error("xtal not selected");

   sequence s_tick;
      ext_div8_tick;
   endsequence
   property p_tick_spacing;
      @(posedge clk_sys) disable iff (!rst_n)
      s_tick |=> !ext_div8_tick [*7];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("div8 ticks too close");

   property p_tick_needs_run;
      @(posedge clk_sys) disable iff (!rst_n)
      ext_div8_tick |-> $past(run);
   endproperty
   a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick while off");
endmodule

// ---- testbench/osc_model.sv ----
// External oscillator source model driving the oscillator pin
`timescale 1ns/10ps
module osc_model #(
   parameter int HALF_NS = 215
) (
   input  wire logic run,
   output logic      osc
);
   // ****************************************
   // Free oscillation while the drive runs
   // ****************************************
   initial osc = 1'b0;
   // Period 430 ns stays slower than the system clock
   always begin
      #(HALF_NS);
      if (run) begin
         osc = ~osc;
      end else begin
         osc = 1'b0;
      end
   end
endmodule

// ---- testbench/external_oscillator_control_tb.sv ----
// Testbench: register, mode decode, crystal valid flag, divided clock, interrupts
`timescale 1ns/10ps
module external_oscillator_control_tb;
   localparam int SETTLE = 20;
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        osc_in;
   logic        ext_clk_out;
   logic        ext_div8_tick;
   logic        irq;
   logic [31:0] rd;
   logic [2:0]  f;
   ext_osc_pkg::analog_ctl_s analog_ctl;
   int          errors     = 0;
   int          num_checks = 0;
   int          cyc        = 0;
   int          t0;
   int          no;
   int          ne;
   int          nt;

   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;

   ext_osc_ctrl #(.SETTLE_CYC(SETTLE), .STABLE_EDGES(2)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .osc_in(osc_in), .analog_ctl(analog_ctl), .ext_clk_out(ext_clk_out),
      .ext_div8_tick(ext_div8_tick), .irq(irq));
   osc_model osc_u (.run(analog_ctl.drive_en), .osc(osc_in));

   // ****************************************
   // Tasks and functions
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      num_checks++;
      if (got < lo || got > hi) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic measure(input int n);
      logic po;
      logic pe;
      no = 0;
      ne = 0;
      nt = 0;
      po = osc_in;
      pe = ext_clk_out;
      repeat (n) begin
         @(posedge clk_sys);
         if (osc_in === 1'b1 && po === 1'b0) no++;
         if (ext_clk_out === 1'b1 && pe === 1'b0) ne++;
         if (ext_div8_tick === 1'b1) nt++;
         po = osc_in;
         pe = ext_clk_out;
      end
   endtask

   function automatic logic [7:0] exp_ana(input logic [2:0] m, input logic [2:0] fq);
      logic on;
      on = m[2] | m[1];
      exp_ana = {on, m[2:1] == 2'b11, m[2:1] == 2'b01, m == 3'b100, m == 3'b101, fq};
   endfunction

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      #5_000_000;
      errors++;
      test_done;
   end

   initial begin
      void'($urandom(26));
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, 12'h0F0, 32'h0);
      chk(rd, 32'h0);
      $display("test reset done");
      f = 3'($urandom);
      apb(1'b1, ext_osc_pkg::ADDR_IRQ_EN, 32'h7);
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, {24'h0, 5'b00001, f});
      apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
      chk(rd, {29'h0, f});
      apb(1'b0, ext_osc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h4);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ext_osc_pkg::ADDR_IRQ_EN, 32'h0);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ext_osc_pkg::ADDR_IRQ_CLR, 32'h4);
      apb(1'b0, ext_osc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ext_osc_pkg::ADDR_IRQ_CLR, 32'h0);
      chk(rd, 32'h0);
      $display("test reserved bit and interrupt done");
      for (int m = 0; m < 8; m++) begin
         f = 3'($urandom);
         apb(1'b1, ext_osc_pkg::ADDR_CTRL, {24'h0, 1'b0, 3'(m), 1'b0, f});
         apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
         chk(rd & 32'h7F, {25'h0, 3'(m), 1'b0, f});
         chk({24'h0, analog_ctl} & (m > 1 ? 32'hFF : 32'hF8),
             {24'h0, exp_ana(3'(m), f)} & (m > 1 ? 32'hFF : 32'hF8));
      end
      $display("test mode decode done");
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, 32'h27);
      measure(600);
      chk_rng(no, 100, 200);
      chk_rng(ne, no - 1, no + 1);
      chk_rng(nt, no / 8 - 1, no / 8 + 1);
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, 32'h37);
      measure(600);
      chk_rng(no, 100, 200);
      chk_rng(ne, no / 2 - 1, no / 2 + 1);
      chk_rng(nt, no / 8 - 1, no / 8 + 1);
      $display("test divided clock done");
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, ext_osc_pkg::ADDR_IRQ_CLR, 32'h7);
      // Pins taken as prepared before crystal enable
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, 32'h67);
      t0 = cyc;
      apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      for (int i = 0; i < 100 && rd[7] !== 1'b1; i++) apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
      chk({31'h0, rd[7]}, 32'h1);
      chk_rng(cyc - t0, SETTLE, 400);
      apb(1'b0, ext_osc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, ext_osc_pkg::ADDR_CTRL, 32'h27);
      apb(1'b0, ext_osc_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h27);
      apb(1'b0, ext_osc_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      $display("test crystal valid done");
      test_done;
   end
endmodule
